/* File: hdl/oms_defines.svh */
// Offsets, field positions, reset values and setting codes of the mode selector
// Functional notes
// - Panel/external change only when stopped, start off, except in mode 6 and in mode 7 with interlock OFF
// - Panel/external select honoured for modes 0, 6, 7
// - Terminal function 16 routes panel/external select
// - Select ON external; 1 panel; 2 external; 3,4 combined
// - Mode 7: interlock ON follows inputs, else external
// - Priority: mode, interlock, link/ext, link/panel, panel/ext, startup
// - Link selects reach network for modes 0, 2, 6; link/external also in 7
// - Link/panel select ON panel, OFF network
// - Startup 10: mode 2 network, 7 external/panel
// - Link/panel panel choice becomes network if link/external ON
// - Link/panel network choice follows panel/external select
// - Link/external select ON network, OFF external
// - Mode 2 link/external enters panel only when network has no source
// - Network without source becomes panel
// - Link/external external choice: panel/external or link/panel
// - Mode 7 link/external switching needs interlock ON
`ifndef OMS_DEFINES_SVH
`define OMS_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define OMS_ADDR_CFG 8'h00
`define OMS_ADDR_STATUS 8'h04
`define OMS_ADDR_FUNC0 8'h08
`define OMS_ADDR_FUNC6 8'h20
`define OMS_NUM_TERM 7

// ****************************************************************
// Configuration fields and reset values
// ****************************************************************
`define OMS_CFG_MODE_LSB 0
`define OMS_CFG_START_LSB 8
`define OMS_CFG_SRC_LSB 16
`define OMS_MODE_RST 3'h0
`define OMS_START_RST 4'h0
`define OMS_SRC_RST 2'h0
`define OMS_FUNC_RST 8'h00

// ****************************************************************
// Setting codes
// ****************************************************************
`define OMS_MODE_ANY 3'h0
`define OMS_MODE_PANEL 3'h1
`define OMS_MODE_EXT 3'h2
`define OMS_MODE_COMB3 3'h3
`define OMS_MODE_COMB4 3'h4
`define OMS_MODE_SWITCH 3'h6
`define OMS_MODE_ILOCK 3'h7
`define OMS_START_FOLLOW 4'h0
`define OMS_START_NET 4'h1
`define OMS_START_PNL 4'hA
`define OMS_SRC_OPTION 2'h0
`define OMS_FUNC_ILOCK 8'h0C
`define OMS_FUNC_PANEL_EXT 8'h10
`define OMS_FUNC_OSTOP 8'h18
`define OMS_FUNC_LINK_PANEL 8'h41
`define OMS_FUNC_LINK_EXT 8'h42

`define OMS_RESP_OKAY 2'h0
`define OMS_RESP_SLVERR 2'h2

`endif

/* File: hdl/oms_pkg.sv */
// Types shared by the mode selector modules
package oms_pkg;
	typedef enum logic [1:0] {OMS_EXTERNAL, OMS_PANEL, OMS_NETWORK, OMS_COMBINED} oms_mode_e;
endpackage : oms_pkg

/* File: hdl/oms_if.sv */
// Decision inputs and result passed between the top and the resolver
`timescale 1ns/10ps
interface oms_if import oms_pkg::*; ();
	logic [2:0] mode_sel;
	logic [3:0] startup;
	logic net_ok;
	logic ilock_on;
	logic lext_asg;
	logic lext;
	logic lpnl_asg;
	logic lpnl;
	logic pext_asg;
	logic pext;
	oms_mode_e target;
	logic run_ok;
	modport top (output mode_sel, startup, net_ok, ilock_on, lext_asg, lext, lpnl_asg,
		lpnl, pext_asg, pext, input target, run_ok);
	modport res (input mode_sel, startup, net_ok, ilock_on, lext_asg, lext, lpnl_asg,
		lpnl, pext_asg, pext, output target, run_ok);
endinterface : oms_if

/* File: hdl/oms_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module oms_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : oms_sync

/* File: hdl/oms_resolve.sv */
// Priority resolver for the operation mode
`timescale 1ns/10ps
`include "oms_defines.svh"
module oms_resolve import oms_pkg::*; (
	oms_if.res bus
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	wire logic [2:0] m = bus.mode_sel;
	wire logic st_pnl = (bus.startup == `OMS_START_PNL);
	wire logic st_net = (bus.startup == `OMS_START_NET);
	wire oms_mode_e net_or_pnl = bus.net_ok ? OMS_NETWORK : OMS_PANEL;
	wire logic pext_ok = (m == `OMS_MODE_ANY) || (m == `OMS_MODE_SWITCH)
		|| (m == `OMS_MODE_ILOCK);
	wire logic link_ok = (m == `OMS_MODE_ANY) || (m == `OMS_MODE_EXT)
		|| (m == `OMS_MODE_SWITCH) || (m == `OMS_MODE_ILOCK);
	wire logic lext_cfg = bus.lext_asg && !st_pnl && link_ok;
	wire logic lpnl_cfg = bus.lpnl_asg && st_pnl && link_ok;
	// Panel/external select result, external when unassigned
	wire oms_mode_e pext_mode = (bus.pext_asg && !bus.pext) ? OMS_PANEL : OMS_EXTERNAL;
	// Startup default when no selecting input is assigned
	wire logic start_net = (m == `OMS_MODE_ILOCK) ? st_net : (st_net || st_pnl);

	always_comb begin
		bus.target = OMS_EXTERNAL;
		bus.run_ok = (m == `OMS_MODE_SWITCH);
		// Setting first, then interlock, then link inputs, then panel/external, startup last
		case (m)
			`OMS_MODE_PANEL: bus.target = OMS_PANEL;
			`OMS_MODE_COMB3, `OMS_MODE_COMB4: bus.target = OMS_COMBINED;
			`OMS_MODE_ANY, `OMS_MODE_EXT, `OMS_MODE_SWITCH, `OMS_MODE_ILOCK: begin
				if ((m == `OMS_MODE_ILOCK) && !bus.ilock_on) begin
					bus.target = OMS_EXTERNAL;
					bus.run_ok = 1'b1;
				end else if (lext_cfg) begin
					if (bus.lext) begin
						bus.target = net_or_pnl;
					end else if (m == `OMS_MODE_EXT) begin
						bus.target = OMS_EXTERNAL;
					end else if (bus.lpnl_asg) begin
						bus.target = bus.lpnl ? OMS_PANEL : net_or_pnl;
					end else begin
						bus.target = pext_mode;
					end
				end else if (lpnl_cfg && (m == `OMS_MODE_EXT)) begin
					bus.target = net_or_pnl;
				end else if (lpnl_cfg && (m == `OMS_MODE_ILOCK)) begin
					bus.target = pext_mode;
				end else if (lpnl_cfg) begin
					if (bus.lpnl) begin
						bus.target = (bus.lext_asg && bus.lext) ? net_or_pnl : OMS_PANEL;
					end else if (bus.pext_asg) begin
						bus.target = pext_mode;
					end else begin
						bus.target = net_or_pnl;
					end
				end else if (bus.pext_asg && pext_ok) begin
					bus.target = pext_mode;
				end else if (start_net && (m != `OMS_MODE_EXT || !st_pnl)) begin
					bus.target = net_or_pnl;
				end else if (st_pnl && (m == `OMS_MODE_EXT)) begin
					bus.target = net_or_pnl;
				end else begin
					bus.target = OMS_EXTERNAL;
				end
			end
			default: bus.target = OMS_EXTERNAL;
		endcase
	end
endmodule : oms_resolve

/* File: hdl/oms_top.sv */
// Operation mode selector with AXI4-Lite register access
`timescale 1ns/10ps
`include "oms_defines.svh"
module oms_top import oms_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] terminal_in,
	input wire logic motor_stopped,
	input wire logic start_cmd,
	input wire logic comms_option_fitted,
	output logic [1:0] op_mode,
	output logic output_stop,
	output logic change_pending
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [6:0] term_s;
	logic [2:0] misc_s;

	oms_sync #(.W(7)) u_sync_term (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(terminal_in),
		.q(term_s)
	);

	oms_sync #(.W(3)) u_sync_misc (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({comms_option_fitted, start_cmd, motor_stopped}),
		.q(misc_s)
	);

	wire logic stopped_s = misc_s[0];
	wire logic start_s = misc_s[1];
	wire logic option_s = misc_s[2];

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [2:0] mode_select_param_r;
	logic [3:0] startup_mode_param_r;
	logic [1:0] link_cmd_source_param_r;
	logic [7:0] func_r [`OMS_NUM_TERM];
	oms_mode_e mode_r;

	// ****************************************************************
	// Terminal function routing
	// ****************************************************************
	logic [6:0] hit_ilock;
	logic [6:0] hit_pext;
	logic [6:0] hit_ostop;
	logic [6:0] hit_lpnl;
	logic [6:0] hit_lext;

	for (genvar i = 0; i < `OMS_NUM_TERM; i++) begin : g_route
		assign hit_ilock[i] = (func_r[i] == `OMS_FUNC_ILOCK);
		assign hit_pext[i] = (func_r[i] == `OMS_FUNC_PANEL_EXT);
		assign hit_ostop[i] = (func_r[i] == `OMS_FUNC_OSTOP);
		assign hit_lpnl[i] = (func_r[i] == `OMS_FUNC_LINK_PANEL);
		assign hit_lext[i] = (func_r[i] == `OMS_FUNC_LINK_EXT);
	end

	wire logic ilock_asg = |hit_ilock;
	wire logic ostop_in = |(hit_ostop & term_s);
	// Without an interlock terminal the output stop input doubles as the interlock
	wire logic ilock_lvl = ilock_asg ? |(hit_ilock & term_s) : ostop_in;
	wire logic mode_ilock = (mode_select_param_r == `OMS_MODE_ILOCK);

	// ****************************************************************
	// Resolver
	// ****************************************************************
	oms_if dec ();

	assign dec.mode_sel = mode_select_param_r;
	assign dec.startup = startup_mode_param_r;
	assign dec.net_ok = (link_cmd_source_param_r != `OMS_SRC_OPTION) || option_s;
	assign dec.ilock_on = ilock_lvl;
	assign dec.lext_asg = |hit_lext;
	assign dec.lext = |(hit_lext & term_s);
	assign dec.lpnl_asg = |hit_lpnl;
	assign dec.lpnl = |(hit_lpnl & term_s);
	assign dec.pext_asg = |hit_pext;
	assign dec.pext = |(hit_pext & term_s);

	oms_resolve u_resolve (
		.bus(dec)
	);

	// ****************************************************************
	// Mode register
	// ****************************************************************
	// A change waits for motor stopped and start off unless running changes are allowed
	wire logic stop_cond = stopped_s && !start_s;
	wire logic want_change = (dec.target != mode_r);
	wire logic do_change = want_change && (stop_cond || dec.run_ok);
	wire oms_mode_e mode_nxt = do_change ? dec.target : mode_r;
	// Mode 7: interlock ON stops the output while external; other modes follow the output stop input
	wire logic ostop_nxt = mode_ilock ? (ilock_lvl && (mode_nxt == OMS_EXTERNAL))
		: ostop_in;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= OMS_EXTERNAL;
			output_stop <= 1'b0;
			change_pending <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			output_stop <= ostop_nxt;
			change_pending <= want_change && !do_change;
		end
	end

	assign op_mode = mode_r;

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	// Address and data are taken together; one write at a time
	wire logic wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	wire logic [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
	wire logic wa_cfg = (wa == `OMS_ADDR_CFG);
	wire logic wa_func = (wa >= `OMS_ADDR_FUNC0) && (wa <= `OMS_ADDR_FUNC6);
	wire logic [2:0] wa_idx = 3'(wa[7:2] - 6'h02);
	wire logic wa_ok = wa_cfg || (wa == `OMS_ADDR_STATUS) || wa_func;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OMS_RESP_OKAY;
		end else begin
			s_axi_awready <= wr_take;
			s_axi_wready <= wr_take;
			if (wr_take) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wa_ok ? `OMS_RESP_OKAY : `OMS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_select_param_r <= `OMS_MODE_RST;
			startup_mode_param_r <= `OMS_START_RST;
			link_cmd_source_param_r <= `OMS_SRC_RST;
		end else if (wr_take && wa_cfg) begin
			if (s_axi_wstrb[0]) begin
				mode_select_param_r <= s_axi_wdata[`OMS_CFG_MODE_LSB +: 3];
			end
			if (s_axi_wstrb[1]) begin
				startup_mode_param_r <= s_axi_wdata[`OMS_CFG_START_LSB +: 4];
			end
			if (s_axi_wstrb[2]) begin
				link_cmd_source_param_r <= s_axi_wdata[`OMS_CFG_SRC_LSB +: 2];
			end
		end
	end

	for (genvar i = 0; i < `OMS_NUM_TERM; i++) begin : g_func
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				func_r[i] <= `OMS_FUNC_RST;
			end else if (wr_take && wa_func && (wa_idx == 3'(i)) && s_axi_wstrb[0]) begin
				func_r[i] <= s_axi_wdata[7:0];
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	wire logic rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	wire logic [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire logic ra_func = (ra >= `OMS_ADDR_FUNC0) && (ra <= `OMS_ADDR_FUNC6);
	wire logic [2:0] ra_idx = 3'(ra[7:2] - 6'h02);
	wire logic [31:0] cfg_word = {14'h0000, link_cmd_source_param_r, 4'h0,
		startup_mode_param_r, 5'h00, mode_select_param_r};
	// Status shows the block's own state: mode, stop, pending, stop condition
	wire logic [31:0] status_word = {27'h0000000, stop_cond, change_pending, output_stop,
		mode_r};
	wire logic [31:0] func_word = ra_func ? {24'h000000, func_r[ra_idx]} : 32'h00000000;
	wire logic ra_ok = (ra == `OMS_ADDR_CFG) || (ra == `OMS_ADDR_STATUS) || ra_func;
	wire logic [31:0] rd_word = (ra == `OMS_ADDR_CFG) ? cfg_word
		: (ra == `OMS_ADDR_STATUS) ? status_word : func_word;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `OMS_RESP_OKAY;
		end else begin
			s_axi_arready <= rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= ra_ok ? `OMS_RESP_OKAY : `OMS_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Protection bits carry no meaning for this block
	wire logic prot_unused = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:24],
		s_axi_wstrb[3], s_axi_wdata[23:18], s_axi_wdata[15:12], s_axi_wdata[7:3]};
endmodule : oms_top

/* File: testbench/oms_chk.sv */
// Port checker for the operation mode selector
`timescale 1ns/10ps
module oms_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] terminal_in,
	input wire logic motor_stopped,
	input wire logic start_cmd,
	input wire logic comms_option_fitted,
	input wire logic [1:0] op_mode,
	input wire logic change_pending
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wr_take_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
		|=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
	rd_take_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		|=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
	ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read moved");
	wr_unmap_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
		&& s_axi_awaddr[7:2] > 6'h08 |=> s_axi_bresp == 2'h2) else $error("unmapped write ok");
	rd_unmap_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		&& s_axi_araddr[7:2] > 6'h08 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read ok");
	// Unassigned high terminals toggle freely, so only the used ones gate this
	mode_hold_a: assert property ((!s_axi_bvalid && $stable({terminal_in[3:0],
		motor_stopped, start_cmd, comms_option_fitted}))[*4] |-> $stable(op_mode))
		else $error("mode moved");
	// A held change must leave the mode register untouched on that edge
	pend_hold_a: assert property (change_pending |-> $stable(op_mode))
		else $error("mode moved while held");
endmodule : oms_chk

/* File: testbench/oms_term_model.sv */
// Terminal and panel side model driving the selector pins
`timescale 1ns/10ps
module oms_term_model (
	input wire logic aclk,
	output logic [6:0] terminal_in,
	output logic motor_stopped,
	output logic start_cmd,
	output logic comms_option_fitted
);
	logic [3:0] used_r = 4'h0;
	// Spare terminals take a fresh random value every cycle, so a stray decode shows up
	always @(posedge aclk) terminal_in <= {3'($urandom), used_r};
	task automatic set_pins(input logic [3:0] t, input logic stp, input logic st, input logic cf);
		used_r <= t;
		motor_stopped <= stp;
		start_cmd <= st;
		comms_option_fitted <= cf;
	endtask : set_pins
endmodule : oms_term_model

/* File: testbench/oms_top_tb_top.sv */
// Self-checking bench for the operation mode selector
`timescale 1ns/10ps
module oms_top_tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, op_mode;
	logic [6:0] terminal_in;
	logic motor_stopped, start_cmd, comms_option_fitted, output_stop, change_pending;
	int err_count, tests_run;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	logic [2:0] mv[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
	logic [1:0] me[5] = '{2'h1, 2'h0, 2'h3, 2'h3, 2'h1};
	logic [31:0] rnd;
	oms_top dut (.*);
	oms_term_model term (.*);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic note_miss(input string m);
		$display("mismatch at %0t: %s", $time, m);
		err_count++;
	endtask : note_miss
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic cmp_wr(input logic [1:0] r);
		tests_run++;
		if (r !== bq.pop_front()) note_miss("write response");
	endtask : cmp_wr
	task automatic cmp_pin(input logic [3:0] p, input logic [3:0] e);
		tests_run++;
		if (p !== e) note_miss("mode pins");
	endtask : cmp_pin
	task automatic cmp_rd(input logic [31:0] d, input logic [1:0] r);
		logic [65:0] e;
		e = rq.pop_front();
		tests_run++;
		if ({r, d & e[63:32]} !== {e[65:64], e[31:0]}) note_miss("read data or response");
		// Status reads also hold the output pins against the same expectation
		if (e[63:32] == 32'h0000001F) begin
			cmp_pin({change_pending, output_stop, op_mode}, e[3:0]);
		end
	endtask : cmp_rd
	// ****************************************************************
	// Monitor: takes the oldest note whenever a response completes
	// ****************************************************************
	always @(posedge aclk) begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) cmp_wr(s_axi_bresp);
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp_rd(s_axi_rdata, s_axi_rresp);
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		bq.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($urandom);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (!(s_axi_bvalid && s_axi_bready)) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
		s_axi_bready <= 1'b0;
		if (n >= 50) begin
			note_miss("write timeout");
			report_and_stop();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		rq.push_back({er, m, e & m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (!(s_axi_rvalid && s_axi_rready)) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
		s_axi_rready <= 1'b0;
		if (n >= 50) begin
			note_miss("read timeout");
			report_and_stop();
		end
	endtask : rd
	task automatic pins(input logic [3:0] t, input logic stp, input logic st, input logic cf);
		@(posedge aclk);
		term.set_pins(t, stp, st, cf);
	endtask : pins
	// Pins cross two sync flops before the mode register, so wait past that
	task automatic chk(input logic [1:0] md, input logic os, input logic pd);
		repeat (6) @(posedge aclk);
		rd(8'h04, {27'h0, term.motor_stopped & ~term.start_cmd, pd, os, md}, 32'h1F, 2'h0);
	endtask : chk
	initial begin
		void'($urandom(52396));
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
		term.set_pins(4'h0, 1'h1, 1'h0, 1'h1);
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
		rd(8'h08, 32'h0, 32'hFFFFFFFF, 2'h0);
		chk(2'h0, 1'h0, 1'h0);
		rd(8'h40, 32'h0, 32'hFFFFFFFF, 2'h2);
		wr(8'h40, 32'hFFFFFFFF, 2'h2);
		wr(8'h04, 32'hFFFFFFFF, 2'h0);
		wr(8'h08, 32'h10, 2'h0);
		chk(2'h1, 1'h0, 1'h0);
		pins(4'h1, 1'h1, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h0);
		pins(4'h0, 1'h0, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h1);
		pins(4'h0, 1'h1, 1'h1, 1'h1);
		chk(2'h0, 1'h0, 1'h1);
		pins(4'h0, 1'h1, 1'h0, 1'h1);
		chk(2'h1, 1'h0, 1'h0);
		for (int i = 0; i < 5; i++) begin
			wr(8'h00, {29'h0, mv[i]}, 2'h0);
			chk(me[i], 1'h0, 1'h0);
		end
		pins(4'h1, 1'h0, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h0);
		wr(8'h0C, 32'h0C, 2'h0);
		pins(4'h2, 1'h1, 1'h0, 1'h1);
		wr(8'h00, 32'h7, 2'h0);
		chk(2'h1, 1'h0, 1'h0);
		pins(4'h3, 1'h1, 1'h0, 1'h1);
		chk(2'h0, 1'h1, 1'h0);
		pins(4'h2, 1'h1, 1'h0, 1'h1);
		chk(2'h1, 1'h0, 1'h0);
		pins(4'h0, 1'h0, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h0);
		wr(8'h14, 32'h42, 2'h0);
		pins(4'h8, 1'h1, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h0);
		pins(4'hA, 1'h1, 1'h0, 1'h1);
		chk(2'h2, 1'h0, 1'h0);
		wr(8'h00, 32'h2, 2'h0);
		pins(4'h0, 1'h1, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h0);
		pins(4'h8, 1'h1, 1'h0, 1'h1);
		chk(2'h2, 1'h0, 1'h0);
		pins(4'h0, 1'h0, 1'h0, 1'h1);
		chk(2'h2, 1'h0, 1'h1);
		// Link/external off with panel/external off lands in panel, even while running
		wr(8'h00, 32'h6, 2'h0);
		chk(2'h1, 1'h0, 1'h0);
		wr(8'h10, 32'h41, 2'h0);
		wr(8'h00, 32'hA02, 2'h0);
		pins(4'h4, 1'h1, 1'h0, 1'h1);
		chk(2'h2, 1'h0, 1'h0);
		pins(4'h4, 1'h1, 1'h0, 1'h0);
		chk(2'h1, 1'h0, 1'h0);
		wr(8'h00, 32'hA00, 2'h0);
		pins(4'h4, 1'h1, 1'h0, 1'h1);
		chk(2'h1, 1'h0, 1'h0);
		pins(4'hC, 1'h1, 1'h0, 1'h1);
		chk(2'h2, 1'h0, 1'h0);
		pins(4'h1, 1'h1, 1'h0, 1'h1);
		chk(2'h0, 1'h0, 1'h0);
		pins(4'h0, 1'h1, 1'h0, 1'h1);
		chk(2'h1, 1'h0, 1'h0);
		// Reset in mid-run clears every register and the mode
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h10, 32'h0, 32'hFFFFFFFF, 2'h0);
		chk(2'h0, 1'h0, 1'h0);
		rnd = $urandom | 32'h80;
		wr(8'h20, rnd, 2'h0);
		rd(8'h20, {24'h0, rnd[7:0]}, 32'hFFFFFFFF, 2'h0);
		repeat (4) @(posedge aclk);
		report_and_stop();
	end
endmodule : oms_top_tb_top
bind oms_top oms_chk chk_i (.*);
